/* rtl/dfp_pkg.sv */
// constants and carrier types for the two dma fifo port controllers
package dfp_pkg;

	// sizes
	localparam int PORTS = 2;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int LEN_W = 11;
	localparam int ADDR_W = 8;
	localparam int EP_BITS = 8;

	// register offsets, one entry per port
	localparam logic [PORTS-1:0][ADDR_W-1:0] CFG_OFS = {8'h50, 8'h48};
	localparam logic [PORTS-1:0][ADDR_W-1:0] CTRL_OFS = {8'h52, 8'h4a};
	localparam logic [PORTS-1:0][ADDR_W-1:0] COUNT_OFS = {8'h56, 8'h4e};

	// configuration register fields
	localparam int CFG_BURST = 15;
	localparam int CFG_TIMING = 9;
	localparam int CFG_ENABLE = 8;
	localparam int CFG_SWAP = 7;
	localparam int CFG_NARROW = 6;
	localparam int CFG_EP_LSB = 0;
	localparam logic [15:0] CFG_WMASK = 16'h83cf;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// control register fields
	localparam int CTRL_COUNT_CLEAR = 15;
	localparam int CTRL_COUNT_ENABLE = 14;
	localparam int CTRL_VALID = 13;
	localparam int CTRL_BUF_CLEAR = 12;
	localparam int CTRL_NOT_READY = 11;
	localparam int CTRL_LEN_LSB = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0800;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// legal endpoint numbers for a port
	localparam logic [3:0] EP_FIRST = 4'h1;
	localparam logic [3:0] EP_LAST = 4'h6;

	// configuration fields as stored
	typedef struct packed {
		logic burst_select;
		logic ready_flag_timing_mode;
		logic dma_request_enable;
		logic byte_lane_swap;
		logic narrow;
		logic [3:0] port_endpoint_select;
	} dfp_cfg_type;

	// one buffer word: odd marks a single valid low byte, last ends a packet
	typedef struct packed {
		logic odd;
		logic last;
		logic [DATA_W-1:0] data;
	} dfp_word_type;

endpackage

/* rtl/dfp_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dfp_sync #(
	parameter int WIDTH = 1
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// pin side and clean side
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import dfp_pkg::*;

	logic [WIDTH-1:0] meta_reg; // first stage, read only by the second

	// both stages reset to zero; the first is never looked at by logic
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* rtl/dfp_fifo.sv */
// word fifo with flush, valid and ready on both sides
`timescale 1ns/1ns
module dfp_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic flush,
	// fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import dfp_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] fill_reg; // one bit wider so full is honest
	logic push;
	logic pop;

	assign in_ready = (fill_reg != (AW+1)'(DEPTH));
	assign out_valid = (fill_reg != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_reg];

	// storage write
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and fill level; flush drops everything queued
	always_ff @(posedge clk) begin
		if (sys_rst || (ce && flush)) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
		end else if (ce) begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				fill_reg <= fill_reg + 1'b1;
			end else if (pop && !push) begin
				fill_reg <= fill_reg - 1'b1;
			end
		end
	end
endmodule

/* rtl/dfp_dma_port.sv */
// two dma fifo port controllers: configuration, control, request handshake, data path
`timescale 1ns/1ns
module dfp_dma_port (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// register port, byte address
	input wire logic [dfp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// device pins
	input wire logic bus_width_pin,
	input wire logic [dfp_pkg::PORTS-1:0] dma_acknowledge_pin,
	input wire logic [dfp_pkg::DATA_W-1:0] dma_wdata_pin,
	output logic [dfp_pkg::PORTS-1:0] dma_request,
	output logic [dfp_pkg::DATA_W-1:0] dma_rdata,
	// endpoint configuration, one bit per endpoint number
	input wire logic [dfp_pkg::EP_BITS-1:0] endpoint_direction,
	input wire logic [dfp_pkg::EP_BITS-1:0] endpoint_narrow_width,
	// receive words from the endpoint buffer
	input wire dfp_pkg::dfp_word_type [dfp_pkg::PORTS-1:0] rx_word,
	input wire logic [dfp_pkg::PORTS-1:0] rx_valid,
	output logic [dfp_pkg::PORTS-1:0] rx_ready,
	input wire logic [dfp_pkg::PORTS-1:0] rx_packet_done,
	input wire logic [dfp_pkg::PORTS-1:0][dfp_pkg::LEN_W-1:0] rx_packet_len,
	// transmit words toward the endpoint buffer
	output dfp_pkg::dfp_word_type [dfp_pkg::PORTS-1:0] tx_word,
	output logic [dfp_pkg::PORTS-1:0] tx_valid,
	input wire logic [dfp_pkg::PORTS-1:0] tx_ready,
	input wire logic [dfp_pkg::PORTS-1:0] tx_buffer_full,
	input wire logic [dfp_pkg::PORTS-1:0] tx_sent,
	// events toward the endpoint and interrupt logic
	output logic [dfp_pkg::PORTS-1:0] tx_commit,
	output logic [dfp_pkg::PORTS-1:0] buffer_flush,
	output logic [dfp_pkg::PORTS-1:0] endpoint_buffer_ready
);
	import dfp_pkg::*;

	// byte bus pin, both acknowledges and the write data share one synchroniser
	localparam int PIN_W = DATA_W + PORTS + 1;

	// synchronised pins
	logic [PIN_W-1:0] pin_sync; // {byte bus, acknowledges, write data}
	logic byte_bus; // pin low selects the 8-bit bus
	logic [PORTS-1:0] dma_acknowledge_pin_sync; // acknowledge levels after two flops
	logic [PORTS-1:0] dma_acknowledge_pin_prev_reg; // for edge detection on the clean level
	logic [DATA_W-1:0] wdata_sync;

	// per-port state
	dfp_cfg_type cfg_reg [PORTS];
	logic [PORTS-1:0] count_enable_reg;
	logic [PORTS-1:0] valid_reg;
	logic [LEN_W-1:0] len_reg [PORTS];
	// the counter is kept per port and read back at its own offset
	logic [15:0] count_reg [PORTS];

	// per-port decoded terms
	logic [PORTS-1:0] not_ready; // access-ready flag, 1 means inaccessible
	logic [PORTS-1:0] pop_word; // data register read took a word
	logic [DATA_W-1:0] read_word [PORTS]; // lane-mapped head word

	// all pins pass two flip-flops before any logic sees them
	dfp_sync #(
		.WIDTH(PIN_W)
	) u_pin_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		// the width pin enters inverted so the reset value 0 means its idle wide bus
		.async_in({~bus_width_pin, dma_acknowledge_pin, dma_wdata_pin}),
		.sync_out(pin_sync)
	);

	// no false narrow spell follows reset while the stages refill
	assign byte_bus = pin_sync[PIN_W-1];
	assign dma_acknowledge_pin_sync = pin_sync[DATA_W +: PORTS];
	assign wdata_sync = pin_sync[DATA_W-1:0];

	// previous acknowledge level, taken from the second synchroniser stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dma_acknowledge_pin_prev_reg <= '0;
		end else if (ce) begin
			dma_acknowledge_pin_prev_reg <= dma_acknowledge_pin_sync;
		end
	end

	// each port is an independent copy of the same logic
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		logic ep_ok; // endpoint number is one of the usable ones
		logic [2:0] ep_idx;
		logic is_tx; // selected endpoint is a transmit buffer
		logic is_rx;
		logic narrow_eff;
		logic accessible;
		logic dma_acknowledge_pin_rise;
		logic access;
		logic push_word;
		logic last_read;
		logic cfg_wr;
		logic ctrl_wr;
		logic clear_req;
		logic force_done;
		logic flush_now;
		dfp_word_type pin_word; // write data mapped into buffer order
		dfp_word_type f_in_data;
		dfp_word_type f_out_data;
		logic f_in_valid;
		logic f_in_ready;
		logic f_out_valid;
		logic f_out_ready;

		// only endpoints one to six are usable; any other number leaves the
		// port idle with the access-ready flag showing inaccessible
		assign ep_idx = cfg_reg[p].port_endpoint_select[2:0];
		assign ep_ok = (cfg_reg[p].port_endpoint_select >= EP_FIRST)
			&& (cfg_reg[p].port_endpoint_select <= EP_LAST);
		assign is_tx = ep_ok & endpoint_direction[ep_idx];
		assign is_rx = ep_ok & ~endpoint_direction[ep_idx];
		// byte bus overrides the width bit; either width bit narrows the port
		assign narrow_eff = byte_bus | cfg_reg[p].narrow | endpoint_narrow_width[ep_idx];

		// register write decode
		assign cfg_wr = reg_wr && (reg_addr == CFG_OFS[p]);
		assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFS[p]);
		// receive clear needs a full buffer, transmit clear does not
		assign clear_req = ctrl_wr && reg_wdata[CTRL_BUF_CLEAR]
			&& (is_tx || (is_rx && valid_reg[p]));
		// forced completion only means something on a transmit buffer
		assign force_done = ctrl_wr && reg_wdata[CTRL_VALID] && is_tx;
		assign flush_now = clear_req;

		// the data register is reachable only with data or room behind it
		always_comb begin
			if (is_rx) begin
				accessible = valid_reg[p] & f_out_valid;
			end else if (is_tx) begin
				accessible = f_in_ready & ~valid_reg[p];
			end else begin
				accessible = 1'b0; // no usable endpoint selected
			end
		end
		assign not_ready[p] = ~accessible;

		// an access is one rising edge of the acknowledge
		// the edge is taken on the clean level so a slow pin edge counts once
		assign dma_acknowledge_pin_rise = dma_acknowledge_pin_sync[p] & ~dma_acknowledge_pin_prev_reg[p];
		assign access = dma_acknowledge_pin_rise & accessible;
		// direction decides which access is honoured; the other is dropped
		assign push_word = access & is_tx;
		assign pop_word[p] = access & is_rx;
		assign last_read = pop_word[p] & f_out_data.last;

		// a disabled port never raises the request, whatever the buffer holds
		// request: steal mode drops it while the acknowledge is high,
		// burst mode holds it until the buffer runs dry or fills
		assign dma_request[p] = cfg_reg[p].dma_request_enable & accessible
			& (cfg_reg[p].burst_select | ~dma_acknowledge_pin_sync[p]);

		// write data into buffer order: narrow keeps the low byte only
		always_comb begin
			pin_word.last = 1'b0;
			if (narrow_eff) begin
				pin_word.odd = 1'b1;
				pin_word.data = {8'h00, wdata_sync[7:0]};
			end else if (cfg_reg[p].byte_lane_swap) begin
				pin_word.odd = 1'b0;
				pin_word.data = {wdata_sync[7:0], wdata_sync[15:8]};
			end else begin
				pin_word.odd = 1'b0;
				pin_word.data = wdata_sync;
			end
		end

		// head word into pin order; buffer order is little endian
		always_comb begin
			if (narrow_eff) begin
				read_word[p] = {8'h00, f_out_data.data[7:0]};
			end else if (cfg_reg[p].byte_lane_swap) begin
				read_word[p] = {f_out_data.data[7:0], f_out_data.data[15:8]};
			end else begin
				read_word[p] = f_out_data.data;
			end
		end

		// one fifo serves both directions; the direction bit picks its ends
		// fifo filled by the buffer on receive and by the pins on transmit
		assign f_in_valid = is_tx ? push_word : (is_rx & rx_valid[p]);
		assign f_in_data = is_tx ? pin_word : rx_word[p];
		assign f_out_ready = is_tx ? tx_ready[p] : pop_word[p];
		assign rx_ready[p] = is_rx & f_in_ready;
		assign tx_valid[p] = is_tx & f_out_valid;
		assign tx_word[p] = f_out_data;

		// sixteen words of slack let the dma side run ahead of the buffer
		dfp_fifo #(
			.WIDTH($bits(dfp_word_type)),
			.DEPTH(FIFO_DEPTH)
		) u_fifo (
			.clk(clk),
			.sys_rst(sys_rst),
			.ce(ce),
			.flush(flush_now),
			.in_data(f_in_data),
			.in_valid(f_in_valid),
			.in_ready(f_in_ready),
			.out_data(f_out_data),
			.out_valid(f_out_valid),
			.out_ready(f_out_ready)
		);

		// configuration register; reserved bits are never stored
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				// reset value is taken field by field from the package word
				cfg_reg[p] <= dfp_cfg_type'({CFG_RESET[CFG_BURST], CFG_RESET[CFG_TIMING],
					CFG_RESET[CFG_ENABLE], CFG_RESET[CFG_SWAP], CFG_RESET[CFG_NARROW],
					CFG_RESET[CFG_EP_LSB +: 4]});
			end else if (ce && cfg_wr) begin
				cfg_reg[p].burst_select <= reg_wdata[CFG_BURST];
				cfg_reg[p].ready_flag_timing_mode <= reg_wdata[CFG_TIMING];
				cfg_reg[p].dma_request_enable <= reg_wdata[CFG_ENABLE];
				cfg_reg[p].byte_lane_swap <= reg_wdata[CFG_SWAP];
				cfg_reg[p].narrow <= reg_wdata[CFG_NARROW];
				cfg_reg[p].port_endpoint_select <= reg_wdata[CFG_EP_LSB +: 4];
			end
		end

		// count enable bit
		// counting only advances on received packets; transmit has no count
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				count_enable_reg[p] <= CTRL_RESET[CTRL_COUNT_ENABLE];
			end else if (ce && ctrl_wr) begin
				count_enable_reg[p] <= reg_wdata[CTRL_COUNT_ENABLE];
			end
		end

		// transaction counter: the clear bit is a strobe, never stored
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				count_reg[p] <= COUNT_RESET;
			end else if (ce) begin
				// a clear in the same cycle as a count wins, so software sees zero
				if (ctrl_wr && reg_wdata[CTRL_COUNT_CLEAR]) begin
					count_reg[p] <= COUNT_RESET;
				end else if (count_enable_reg[p] && is_rx && rx_packet_done[p]) begin
					count_reg[p] <= count_reg[p] + 16'h0001;
				end
			end
		end

		// the flag is the buffer state seen by software; it holds across reads
		// buffer flag; a set in the same cycle as a clear wins
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				valid_reg[p] <= CTRL_RESET[CTRL_VALID];
			end else if (ce) begin
				if ((is_rx && rx_packet_done[p]) || force_done
					|| (is_tx && tx_buffer_full[p])) begin
					valid_reg[p] <= 1'b1;
				end else if (clear_req || (is_tx && tx_sent[p])) begin
					valid_reg[p] <= 1'b0;
				end
			end
		end

		// received length, kept after reading so software can fetch it
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				len_reg[p] <= CTRL_RESET[CTRL_LEN_LSB +: LEN_W];
			end else if (ce) begin
				if (is_rx && rx_packet_done[p]) begin
					len_reg[p] <= rx_packet_len[p];
				end else if (clear_req) begin
					len_reg[p] <= '0;
				end
			end
		end

		// one-cycle events toward the endpoint logic
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				tx_commit[p] <= 1'b0;
				buffer_flush[p] <= 1'b0;
				endpoint_buffer_ready[p] <= 1'b0;
			end else if (ce) begin
				// each pulse copies its cause one enabled cycle later and lasts as long as the cause
				tx_commit[p] <= force_done;
				buffer_flush[p] <= clear_req;
				if (cfg_reg[p].ready_flag_timing_mode) begin
					// same moment as an endpoint without a port
					endpoint_buffer_ready[p] <= (is_rx & rx_packet_done[p])
						| (is_tx & tx_sent[p]);
				end else begin
					// only after the last word has gone out to the dma side
					endpoint_buffer_ready[p] <= last_read;
				end
			end
		end
	end

	// shared read data pins; port 0 wins if both read in one cycle,
	// which a single dma controller cannot do anyway
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dma_rdata <= '0;
		end else if (ce) begin
			if (pop_word[0]) begin
				dma_rdata <= read_word[0];
			end else if (pop_word[1]) begin
				dma_rdata <= read_word[1];
			end
		end
	end

	// register read; unmapped offsets answer zero
	// one pass over both ports; at most one offset can match
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (ce && reg_rd) begin
			reg_rdata <= '0;
			for (int i = 0; i < PORTS; i++) begin
				if (reg_addr == CFG_OFS[i]) begin
					reg_rdata <= {cfg_reg[i].burst_select, 5'h00,
						cfg_reg[i].ready_flag_timing_mode,
						cfg_reg[i].dma_request_enable,
						cfg_reg[i].byte_lane_swap,
						cfg_reg[i].narrow & ~byte_bus,
						2'h0, cfg_reg[i].port_endpoint_select};
				end else if (reg_addr == CTRL_OFS[i]) begin
					// clear bits always read back as zero
					reg_rdata <= {1'b0, count_enable_reg[i], valid_reg[i], 1'b0,
						not_ready[i], len_reg[i]};
				end else if (reg_addr == COUNT_OFS[i]) begin
					reg_rdata <= count_reg[i];
				end
			end
		end
	end
endmodule

/* verification/dfp_monitor.sv */
// concurrent checks on the pins of the dma fifo port controllers
`timescale 1ns/1ns
module dfp_monitor (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [dfp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// pins
	input wire logic bus_width_pin,
	input wire logic [dfp_pkg::PORTS-1:0] dma_acknowledge_pin,
	input wire logic [dfp_pkg::PORTS-1:0] dma_request,
	input wire logic [dfp_pkg::EP_BITS-1:0] endpoint_direction,
	input wire logic [dfp_pkg::EP_BITS-1:0] endpoint_narrow_width,
	// buffer side
	input wire dfp_pkg::dfp_word_type [dfp_pkg::PORTS-1:0] tx_word,
	input wire logic [dfp_pkg::PORTS-1:0] tx_valid,
	input wire logic [dfp_pkg::PORTS-1:0] tx_commit,
	input wire logic [dfp_pkg::PORTS-1:0] buffer_flush,
	input wire logic [dfp_pkg::PORTS-1:0] endpoint_buffer_ready
);
	import dfp_pkg::*;
	logic [15:0] cfg_reg; // shadow of the port 0 configuration
	logic [3:0] ep; // endpoint chosen by port 0
	logic wr_ctrl; // write to the port 0 control register
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// the shadow follows writes so the checks know the mode without peeking inside
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_reg <= CFG_RESET;
		end else if (reg_wr && reg_addr == CFG_OFS[0]) begin
			cfg_reg <= reg_wdata & CFG_WMASK;
		end
	end
	assign ep = cfg_reg[3:0];
	assign wr_ctrl = reg_wr && reg_addr == CTRL_OFS[0];
	a_req_gated: assert property (!cfg_reg[CFG_ENABLE] |-> !dma_request[0])
		else $error("request raised while disabled");
	a_steal_drop: assert property (!cfg_reg[CFG_BURST] && dma_request[0] &&
		$rose(dma_acknowledge_pin[0]) |-> ##[1:3] !dma_request[0])
		else $error("steal request not dropped on access");
	a_strobe_reads: assert property (reg_rd && reg_addr == CTRL_OFS[0] |=>
		!reg_rdata[CTRL_COUNT_CLEAR] && !reg_rdata[CTRL_BUF_CLEAR])
		else $error("strobe bit read back as one");
	// the design sees the pin two edges late, so the pin must be low then too
	a_pin_narrow: assert property (reg_rd && reg_addr == CFG_OFS[0] &&
		!bus_width_pin && !$past(bus_width_pin, 2) |=> !reg_rdata[CFG_NARROW])
		else $error("width bit not read as zero");
	a_commit_cause: assert property (tx_commit[0] |->
		$past(wr_ctrl && reg_wdata[CTRL_VALID]))
		else $error("commit without completion write");
	a_flush_cause: assert property (buffer_flush[0] |->
		$past(wr_ctrl && reg_wdata[CTRL_BUF_CLEAR]))
		else $error("flush without clear write");
	a_narrow_upper: assert property (tx_valid[0] && (cfg_reg[CFG_NARROW] ||
		!bus_width_pin || endpoint_narrow_width[ep]) |-> tx_word[0].data[15:8] == 8'h00)
		else $error("upper byte used in narrow mode");
	a_tx_noready: assert property (!cfg_reg[CFG_TIMING] && endpoint_direction[ep] |->
		!endpoint_buffer_ready[0])
		else $error("ready raised on transmit in mode zero");
	a_port_apart: assert property (reg_wr && reg_addr == CTRL_OFS[1] |=>
		!buffer_flush[0] && !tx_commit[0])
		else $error("port 1 write touched port 0");
	c_steal: cover property (dma_request[0] ##[1:3] $rose(dma_acknowledge_pin[0]));
	c_flush: cover property (buffer_flush[0]);
	c_commit: cover property (tx_commit[0]);
endmodule

/* verification/dfp_dma_model.sv */
// behavioural external dma controller for one port
`timescale 1ns/1ns
module dfp_dma_model (
	// system
	input wire logic clk,
	input wire logic slow,
	// handshake pins
	input wire logic req,
	output logic ack,
	output logic [15:0] wd
);
	logic [15:0] wq[$]; // one word per access, filled by the bench
	// access only while the request shows the register ready
	initial begin
		ack = 1'b0;
		wd = 16'h0000;
		forever begin
			@(posedge clk);
			if (req && wq.size() > 0) begin
				repeat (slow ? 3 : 0) @(posedge clk);
				wd <= wq.pop_front();
				ack <= 1'b1;
				// hold long enough for the two-flop sync on both phases
				repeat (4) @(posedge clk);
				ack <= 1'b0;
				wd <= ~wd; // a released line shows no stale word
				repeat (4) @(posedge clk);
			end
		end
	end
endmodule

/* verification/dfp_dma_port_tb.sv */
// self-checking bench for the dma fifo port controllers
`timescale 1ns/1ns
bind dfp_dma_port dfp_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.bus_width_pin(bus_width_pin), .dma_acknowledge_pin(dma_acknowledge_pin),
	.dma_request(dma_request), .endpoint_direction(endpoint_direction),
	.endpoint_narrow_width(endpoint_narrow_width), .tx_word(tx_word), .tx_valid(tx_valid),
	.tx_commit(tx_commit), .buffer_flush(buffer_flush),
	.endpoint_buffer_ready(endpoint_buffer_ready));
module dfp_dma_port_tb;
	import dfp_pkg::*;
	logic clk, sys_rst, ce, reg_wr, reg_rd, bus_width_pin, slow, rd_d;
	logic [ADDR_W-1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, dma_rdata, last_rd, w;
	logic [PORTS-1:0] ack, dma_request, rx_valid, rx_ready, rx_packet_done, tx_valid, tx_ready;
	logic [PORTS-1:0] tx_buffer_full, tx_sent, tx_commit, buffer_flush, endpoint_buffer_ready;
	logic [15:0] wd [PORTS];
	logic [EP_BITS-1:0] endpoint_direction, endpoint_narrow_width;
	dfp_word_type [PORTS-1:0] rx_word, tx_word;
	logic [PORTS-1:0][LEN_W-1:0] rx_packet_len;
	logic [31:0] rq[$]; // mask and value for each register read
	logic [15:0] dq[$]; // words expected on the dma read pins
	logic [16:0] tq[$]; // odd flag and data expected toward the buffer
	int fails, checks_done, n_flush, n_commit, n_rdy;
	dfp_dma_port DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_width_pin(bus_width_pin), .dma_acknowledge_pin(ack),
		.dma_wdata_pin(ack[1] ? wd[1] : wd[0]), .dma_request(dma_request),
		.dma_rdata(dma_rdata), .endpoint_direction(endpoint_direction),
		.endpoint_narrow_width(endpoint_narrow_width), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_packet_done(rx_packet_done),
		.rx_packet_len(rx_packet_len), .tx_word(tx_word), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_buffer_full(tx_buffer_full), .tx_sent(tx_sent),
		.tx_commit(tx_commit), .buffer_flush(buffer_flush),
		.endpoint_buffer_ready(endpoint_buffer_ready));
	// one controller model per port
	for (genvar i = 0; i < PORTS; i++) begin : g
		dfp_dma_model m (.clk(clk), .slow(slow), .req(dma_request[i]), .ack(ack[i]), .wd(wd[i]));
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input logic [16:0] seen, input logic [16:0] want);
		checks_done++;
		if (seen !== want) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		rq.push_back({m, e});
		@(negedge clk);
		reg_rd = 1'b0;
	endtask
	// wait until the model has used up its words
	task idle();
		for (int i = 0; i < 500 && (g[0].m.wq.size() > 0 || ack[0]); i++) @(negedge clk);
		repeat (12) @(negedge clk);
	endtask
	task finish_test();
		$display("checks %0d failures %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// register data lands one edge after the strobe
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk) begin
		if (rd_d) begin
			chk(reg_rdata & rq[0][31:16], rq[0][15:0]);
			rq.delete(0);
		end
		// any change on the read pins must be an expected word
		if (!sys_rst && dma_rdata !== last_rd) begin
			last_rd = dma_rdata;
			chk(dma_rdata, dq.size() ? dq.pop_front() : ~dma_rdata);
		end
	end
	// words handed to the buffer and event pulses, looked at mid-cycle where they stand
	always @(negedge clk) begin
		n_flush += buffer_flush[0];
		n_commit += tx_commit[0];
		n_rdy += endpoint_buffer_ready[0];
		if (tx_valid[0] && tx_ready[0])
			chk({tx_word[0].odd, tx_word[0].data}, tq.size() ? tq.pop_front() : '1);
	end
	// the whole run takes a few hundred cycles, so this only cuts a hang
	initial begin
		#400000;
		fails++;
		finish_test();
	end
	initial begin
		{sys_rst, ce, bus_width_pin} = 3'b111;
		{reg_wr, reg_rd, slow, rd_d} = 4'h0;
		{reg_addr, reg_wdata, last_rd} = '0;
		{rx_word, rx_valid, rx_packet_done, rx_packet_len} = '0;
		{tx_ready, tx_buffer_full, tx_sent} = '0;
		endpoint_direction = 8'h04;
		endpoint_narrow_width = 8'h00;
		void'($urandom(30));
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		rd(CTRL_OFS[0], 16'hffff, CTRL_RESET);
		rd(CFG_OFS[0], 16'hffff, CFG_RESET);
		rd(COUNT_OFS[0], 16'hffff, COUNT_RESET);
		rd(8'h40, 16'hffff, 16'h0000);
		wr(CFG_OFS[1], 16'hffbf);
		wr(CTRL_OFS[1], 16'h3000);
		rd(CTRL_OFS[1], 16'h4800, 16'h0800);
		rd(CFG_OFS[1], 16'hffff, 16'hffbf & CFG_WMASK);
		rd(CFG_OFS[0], 16'hffff, CFG_RESET);
		wr(CFG_OFS[1], 16'h0000);
		$display("test map done");
		// receive three words with the request held off
		wr(CFG_OFS[0], 16'h0201);
		wr(CTRL_OFS[0], 16'h6000);
		rd(CTRL_OFS[0], 16'h6000, 16'h4000);
		for (int i = 0; i < 3; i++) begin
			w = $urandom;
			dq.push_back(w);
			// writes on a receive endpoint are dropped
			g[0].m.wq.push_back(~w);
			rx_word[0] = {1'b0, i == 2, w};
			rx_valid[0] = 1'b1;
			while (rx_ready[0] !== 1'b1) @(negedge clk);
			@(negedge clk);
		end
		rx_valid[0] = 1'b0;
		rx_packet_len[0] = 11'd6;
		rx_packet_done[0] = 1'b1;
		@(negedge clk);
		rx_packet_done[0] = 1'b0;
		repeat (20) @(negedge clk);
		chk(dma_request[0], 1'b0);
		rd(CTRL_OFS[0], 16'hffff, 16'h6006);
		slow = 1'b1;
		wr(CFG_OFS[0], 16'h0101);
		idle();
		wr(CTRL_OFS[0], 16'hc000);
		rd(CTRL_OFS[0], 16'hc000, 16'h4000);
		rd(COUNT_OFS[0], 16'hffff, 16'h0000);
		wr(CTRL_OFS[0], 16'h5000);
		wr(CTRL_OFS[0], 16'h5000);
		$display("test receive done");
		// transmit with lanes swapped, drain stalled until the buffer refuses
		wr(CFG_OFS[0], 16'h0182);
		slow = 1'b0;
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			w = $urandom;
			g[0].m.wq.push_back(w);
			tq.push_back({1'b0, w[7:0], w[15:8]});
		end
		repeat (300) @(negedge clk);
		chk(17'(g[0].m.wq.size()), 17'd1);
		chk(dma_request[0], 1'b0);
		tx_ready[0] = 1'b1;
		idle();
		wr(CTRL_OFS[0], 16'h6000);
		rd(CTRL_OFS[0], 16'h2800, 16'h2800);
		tx_sent[0] = 1'b1;
		@(negedge clk);
		tx_sent[0] = 1'b0;
		rd(CTRL_OFS[0], 16'h2000, 16'h0000);
		$display("test transmit done");
		// narrow through the endpoint bit, then through the pin
		endpoint_narrow_width = 8'h04;
		wr(CFG_OFS[0], 16'h0102);
		for (int i = 0; i < 3; i++) begin
			w = $urandom;
			if (i == 2) begin
				endpoint_narrow_width = 8'h00;
				bus_width_pin = 1'b0;
				wr(CFG_OFS[0], 16'h0142);
				rd(CFG_OFS[0], 16'hffff, 16'h0102);
			end
			g[0].m.wq.push_back(w);
			tq.push_back({1'b1, 8'h00, w[7:0]});
			idle();
		end
		$display("test narrow done");
		chk(17'(n_rdy), 17'd2);
		chk(17'(n_flush), 17'd1);
		chk(17'(n_commit), 17'd1);
		// every noted word and read must have been seen by the watchers
		chk(17'(dq.size() + tq.size() + rq.size()), 17'd0);
		finish_test();
	end
endmodule
